// *** rtl/ees_consts.vh ***
`ifndef EES_CONSTS_VH
`define EES_CONSTS_VH

// Storage array geometry
`define EES_MEM_DEPTH   16384
`define EES_ADDR_W      14
`define EES_PAGE_BYTES  64

// Self-timed programming cycle, longest time rounded down
`define EES_TWR_US      5000
`define EES_CLK_MHZ     50
`define EES_TWR_CYC     (`EES_TWR_US * `EES_CLK_MHZ)

// Byte-level state machine codes
`define EES_ST_IDLE     3'h0
`define EES_ST_RX       3'h1
`define EES_ST_ACK      3'h2
`define EES_ST_TX       3'h3
`define EES_ST_MACK     3'h4
`define EES_ST_SKIP     3'h5

// Field positions of the slave address byte
`define EES_SA_TYPE_HI  7
`define EES_SA_TYPE_LO  4
`define EES_SA_SEL_HI   3
`define EES_SA_SEL_LO   1
`define EES_SA_RW       0

// Byte index within a write transfer
`define EES_IDX_SLAVE   2'h0
`define EES_IDX_ADDRHI  2'h1
`define EES_IDX_ADDRLO  2'h2
`define EES_IDX_DATA    2'h3

`endif

// *** rtl/ees_prog_timer.v ***
`timescale 1ns/10ps
`include "ees_consts.vh"
module ees_prog_timer #(
  parameter CYCLES = `EES_TWR_CYC
) (
  input  wire ref_clk,  // System clock
  input  wire rst,      // Async reset, active high
  input  wire start,    // One-cycle launch pulse
  output wire done      // One-cycle pulse at cycle end
);

  // Launch and done flops add cycles, so busy lasts CYCLES in all
  localparam [31:0] LAST = CYCLES - 3;

  reg  [31:0] count_ff;
  reg         running_ff;
  reg         done_ff;

  assign done = done_ff;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_ff   <= 32'h0;
      running_ff <= 1'b0;
      done_ff    <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start && !running_ff) begin
        count_ff   <= 32'h0;
        running_ff <= 1'b1;
      end else if (running_ff) begin
        if (count_ff == LAST) begin
          running_ff <= 1'b0;
          done_ff    <= 1'b1;
        end else begin
          count_ff <= count_ff + 32'h1;
        end
      end
    end
  end

endmodule // ees_prog_timer

// *** rtl/ees_two_wire_slave.v ***
`timescale 1ns/10ps
`include "ees_consts.vh"
module ees_two_wire_slave #(
  parameter       PROG_CYCLES = `EES_TWR_CYC,
  parameter [3:0] DEV_TYPE    = 4'h5   // Arbitrary value
) (
  input  wire ref_clk,             // 50 MHz system clock
  input  wire rst,                 // Power-on reset, active high
  input  wire sclIn,               // Serial clock pin level
  input  wire sdaIn,               // Serial data pin level
  input  wire deviceSelectBitLow,  // Device select strap, bit 0
  input  wire deviceSelectBitMid,  // Device select strap, bit 1
  input  wire deviceSelectBitHigh, // Device select strap, bit 2
  output wire sdaOut,              // Data drive value, always low
  output wire sdaOe,               // High while pulling data low
  output wire progBusy,            // Programming cycle running
  output wire standby              // Low-power idle
);

  localparam AW = `EES_ADDR_W;

  // Input synchronisers and edge history
  reg          sclSync1_ff;
  reg          sclSync2_ff;
  reg          sclPrev_ff;
  reg          sdaSync1_ff;
  reg          sdaSync2_ff;
  reg          sdaPrev_ff;
  reg  [2:0]   selSync1_ff;
  reg  [2:0]   selSync2_ff;

  // Control state
  reg  [2:0]   state_ff;
  reg  [3:0]   bitCnt_ff;
  reg  [7:0]   shift_ff;
  reg  [7:0]   txByte_ff;
  reg  [1:0]   byteIdx_ff;
  reg          isRead_ff;
  reg  [7:0]   ptrHi_ff;
  reg  [AW-1:0] ptr_ff;
  reg  [7:0]   wrData_ff;
  reg          wrPend_ff;
  reg          masterAck_ff;
  reg          progStart_ff;
  reg          busy_ff;
  reg          sdaOe_ff;
  reg          sdaOut_ff;
  reg          standby_ff;

  reg  [2:0]   nxt_state;
  reg  [3:0]   nxt_bitCnt;
  reg  [7:0]   nxt_shift;
  reg  [7:0]   nxt_txByte;
  reg  [1:0]   nxt_byteIdx;
  reg          nxt_isRead;
  reg  [7:0]   nxt_ptrHi;
  reg  [AW-1:0] nxt_ptr;
  reg  [7:0]   nxt_wrData;
  reg          nxt_wrPend;
  reg          nxt_masterAck;
  reg          nxt_progStart;
  reg          nxt_busy;
  reg          nxt_sdaOe;

  reg  [7:0]   mem [0:`EES_MEM_DEPTH-1];

  wire         progDone;
  wire         sclRise;
  wire         sclFall;
  wire         startEv;
  wire         stopEv;
  wire [7:0]   memRdata;

  function addrMatch;
    input [7:0] sa;
    input [2:0] sel;
    begin
      addrMatch = (sa[`EES_SA_TYPE_HI:`EES_SA_TYPE_LO] == DEV_TYPE) &&
                  (sa[`EES_SA_SEL_HI:`EES_SA_SEL_LO] == sel);
    end
  endfunction

  function [AW-1:0] nextPtr;
    input [AW-1:0] p;
    begin
      nextPtr = p + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  assign sdaOut   = sdaOut_ff;
  assign sdaOe    = sdaOe_ff;
  assign progBusy = busy_ff;
  assign standby  = standby_ff;
  assign memRdata = mem[ptr_ff];

  // Clock is sampled only, never driven
  assign sclRise = sclSync2_ff & ~sclPrev_ff;
  assign sclFall = ~sclSync2_ff & sclPrev_ff;
  // Data edge during a stable clock-high phase
  assign startEv = sclSync2_ff & sclPrev_ff & sdaPrev_ff & ~sdaSync2_ff;
  assign stopEv  = sclSync2_ff & sclPrev_ff & ~sdaPrev_ff & sdaSync2_ff;

  ees_prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) uProgTimer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (progStart_ff),
    .done    (progDone)
  );

  always @* begin
    nxt_state     = state_ff;
    nxt_bitCnt    = bitCnt_ff;
    nxt_shift     = shift_ff;
    nxt_txByte    = txByte_ff;
    nxt_byteIdx   = byteIdx_ff;
    nxt_isRead    = isRead_ff;
    nxt_ptrHi     = ptrHi_ff;
    nxt_ptr       = ptr_ff;
    nxt_wrData    = wrData_ff;
    nxt_wrPend    = wrPend_ff;
    nxt_masterAck = masterAck_ff;
    nxt_progStart = 1'b0;
    nxt_busy      = busy_ff;
    nxt_sdaOe     = sdaOe_ff;

    // Programming finished: counter moves past the written byte
    if (progDone) begin
      nxt_busy = 1'b0;
      nxt_ptr  = nextPtr(ptr_ff);
    end

    if (startEv) begin
      nxt_state   = `EES_ST_RX;
      nxt_bitCnt  = 4'h0;
      nxt_byteIdx = `EES_IDX_SLAVE;
      nxt_sdaOe   = 1'b0;
      nxt_wrPend  = 1'b0;
    end else if (stopEv) begin
      nxt_state = `EES_ST_IDLE;
      nxt_sdaOe = 1'b0;
      if (wrPend_ff && !busy_ff) begin
        nxt_progStart = 1'b1;
        nxt_busy      = 1'b1;
        nxt_wrPend    = 1'b0;
      end
    end else begin
      case (state_ff)
        `EES_ST_RX: begin
          if (sclRise) begin
            nxt_shift  = {shift_ff[6:0], sdaSync2_ff};
            nxt_bitCnt = bitCnt_ff + 4'h1;
          end else if (sclFall && bitCnt_ff == 4'h8) begin
            nxt_bitCnt = 4'h0;
            if (byteIdx_ff != `EES_IDX_DATA) begin
              nxt_byteIdx = byteIdx_ff + 2'h1;
            end
            if (byteIdx_ff == `EES_IDX_SLAVE) begin
              if (addrMatch(shift_ff, selSync2_ff) && !busy_ff) begin
                nxt_sdaOe  = 1'b1;
                nxt_state  = `EES_ST_ACK;
                nxt_isRead = shift_ff[`EES_SA_RW];
              end else begin
                nxt_state = `EES_ST_SKIP;
              end
            end else if (isRead_ff) begin
              nxt_state = `EES_ST_SKIP;
            end else begin
              nxt_sdaOe = 1'b1;
              nxt_state = `EES_ST_ACK;
              case (byteIdx_ff)
                `EES_IDX_ADDRHI: begin
                  nxt_ptrHi = shift_ff;
                end
                `EES_IDX_ADDRLO: begin
                  nxt_ptr = {ptrHi_ff[AW-9:0], shift_ff};
                end
                default: begin
                  nxt_wrData = shift_ff;
                  nxt_wrPend = 1'b1;
                end
              endcase
            end
          end
        end
        `EES_ST_ACK: begin
          if (sclFall) begin
            nxt_bitCnt = 4'h0;
            if (isRead_ff) begin
              nxt_txByte = memRdata;
              nxt_sdaOe  = ~memRdata[7];
              nxt_state  = `EES_ST_TX;
            end else begin
              nxt_sdaOe = 1'b0;
              nxt_state = `EES_ST_RX;
            end
          end
        end
        `EES_ST_TX: begin
          if (sclFall) begin
            if (bitCnt_ff == 4'h7) begin
              nxt_sdaOe = 1'b0;
              nxt_ptr   = nextPtr(ptr_ff);
              nxt_state = `EES_ST_MACK;
            end else begin
              nxt_bitCnt = bitCnt_ff + 4'h1;
              nxt_txByte = {txByte_ff[6:0], 1'b0};
              nxt_sdaOe  = ~txByte_ff[6];
            end
          end
        end
        `EES_ST_MACK: begin
          if (sclRise) begin
            nxt_masterAck = ~sdaSync2_ff;
          end else if (sclFall) begin
            if (masterAck_ff) begin
              nxt_bitCnt = 4'h0;
              nxt_txByte = memRdata;
              nxt_sdaOe  = ~memRdata[7];
              nxt_state  = `EES_ST_TX;
            end else begin
              nxt_state = `EES_ST_SKIP;
            end
          end
        end
        `EES_ST_SKIP: begin
          nxt_sdaOe = 1'b0;
        end
        `EES_ST_IDLE: begin
          nxt_sdaOe = 1'b0;
        end
        default: begin
          nxt_state = `EES_ST_IDLE;
          nxt_sdaOe = 1'b0;
        end
      endcase
    end
  end

  // Reset holds every flop except the array, so bus traffic is ignored meanwhile
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclSync1_ff  <= 1'b1;
      sclSync2_ff  <= 1'b1;
      sclPrev_ff   <= 1'b1;
      sdaSync1_ff  <= 1'b1;
      sdaSync2_ff  <= 1'b1;
      sdaPrev_ff   <= 1'b1;
      selSync1_ff  <= 3'h0;
      selSync2_ff  <= 3'h0;
      state_ff     <= `EES_ST_IDLE;
      bitCnt_ff    <= 4'h0;
      shift_ff     <= 8'h00;
      txByte_ff    <= 8'h00;
      byteIdx_ff   <= `EES_IDX_SLAVE;
      isRead_ff    <= 1'b0;
      ptrHi_ff     <= 8'h00;
      ptr_ff       <= {AW{1'b0}};
      wrData_ff    <= 8'h00;
      wrPend_ff    <= 1'b0;
      masterAck_ff <= 1'b0;
      progStart_ff <= 1'b0;
      busy_ff      <= 1'b0;
      sdaOe_ff     <= 1'b0;
      sdaOut_ff    <= 1'b0;
      standby_ff   <= 1'b1;
    end else begin
      sclSync1_ff  <= sclIn;
      sclSync2_ff  <= sclSync1_ff;
      sclPrev_ff   <= sclSync2_ff;
      sdaSync1_ff  <= sdaIn;
      sdaSync2_ff  <= sdaSync1_ff;
      sdaPrev_ff   <= sdaSync2_ff;
      selSync1_ff  <= {deviceSelectBitHigh, deviceSelectBitMid,
                       deviceSelectBitLow};
      selSync2_ff  <= selSync1_ff;
      state_ff     <= nxt_state;
      bitCnt_ff    <= nxt_bitCnt;
      shift_ff     <= nxt_shift;
      txByte_ff    <= nxt_txByte;
      byteIdx_ff   <= nxt_byteIdx;
      isRead_ff    <= nxt_isRead;
      ptrHi_ff     <= nxt_ptrHi;
      ptr_ff       <= nxt_ptr;
      wrData_ff    <= nxt_wrData;
      wrPend_ff    <= nxt_wrPend;
      masterAck_ff <= nxt_masterAck;
      progStart_ff <= nxt_progStart;
      busy_ff      <= nxt_busy;
      sdaOe_ff     <= nxt_sdaOe;
      sdaOut_ff    <= 1'b0;
      standby_ff   <= (nxt_state == `EES_ST_IDLE) && !nxt_busy;
    end
  end

  // Array is committed when the programming cycle ends
  always @(posedge ref_clk) begin
    if (progDone) begin
      mem[ptr_ff] <= wrData_ff;
    end
  end

endmodule // ees_two_wire_slave

// *** sim/ees_master_model.sv ***
`timescale 1ns/10ps
module ees_master_model (
  input  wire refClk,  // Bench clock
  input  wire sdaIn,   // Resolved data wire
  output reg  scl,     // Serial clock drive
  output reg  sdaDrv   // Data drive, 0 pulls low
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  // Quarter of a 160 ns clock period
  task q;
    begin
      repeat (2) @(posedge refClk);
      #1;
    end
  endtask
  task start;
    begin
      q;
      sdaDrv = 1'b1;
      q;
      scl = 1'b1;
      q;
      sdaDrv = 1'b0;
      q;
      scl = 1'b0;
    end
  endtask
  task xfer(input b, output r);
    begin
      q;
      sdaDrv = b;
      q;
      scl = 1'b1;
      q;
      r = sdaIn;
      q;
      scl = 1'b0;
    end
  endtask
  task wr(input [7:0] v, output ack);
    integer k;
    reg     r;
    begin
      for (k = 7; k >= 0; k = k - 1) xfer(v[k], r);
      xfer(1'b1, r);
      ack = ~r;
    end
  endtask
  task rd(input nak, output [7:0] v);
    integer k;
    reg     r;
    begin
      for (k = 7; k >= 0; k = k - 1) begin
        xfer(1'b1, r);
        v[k] = r;
      end
      xfer(nak, r);
    end
  endtask
  // Clock until data reads high, then start inside that high phase
  task recover;
    integer n;
    reg     r;
    begin
      r = 1'b0;
      n = 0;
      while (!r && n < 9) begin
        q;
        sdaDrv = 1'b1;
        q;
        scl = 1'b1;
        q;
        r = sdaIn;
        if (!r) begin
          q;
          scl = 1'b0;
        end
        n = n + 1;
      end
      sdaDrv = 1'b0;
      q;
      scl = 1'b0;
    end
  endtask
  task stop;
    begin
      q;
      sdaDrv = 1'b0;
      q;
      scl = 1'b1;
      q;
      sdaDrv = 1'b1;
      q;
    end
  endtask
endmodule // ees_master_model

// *** sim/ees_two_wire_slave_properties.sv ***
`timescale 1ns/10ps
`include "ees_consts.vh"
module ees_two_wire_slave_properties #(
  parameter PROG_CYCLES = `EES_TWR_CYC
) (
  input wire ref_clk,             // System clock
  input wire rst,                 // Reset
  input wire sclIn,               // Clock pin
  input wire sdaIn,               // Data wire
  input wire deviceSelectBitLow,  // Strap 0
  input wire deviceSelectBitMid,  // Strap 1
  input wire deviceSelectBitHigh, // Strap 2
  input wire sdaOut,              // Drive value
  input wire sdaOe,               // Pull enable
  input wire progBusy,            // Programming
  input wire standby              // Idle
);
  reg  [31:0] busyCnt_ff;
  wire [31:0] nxt_busyCnt = progBusy ? busyCnt_ff + 32'h1 : 32'h0;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) busyCnt_ff <= 32'h0;
    else busyCnt_ff <= nxt_busyCnt;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_drive_low_only: assert property (sdaOe |-> !sdaOut)
    else $error("data line driven high");
  a_reset_idle: assert property ($fell(rst) |-> standby && !sdaOe
    && !progBusy) else $error("not idle after reset");
  a_busy_length: assert property ($fell(progBusy) |->
    busyCnt_ff >= PROG_CYCLES && busyCnt_ff <= PROG_CYCLES + 1)
    else $error("programming length wrong");
  a_idle_after_prog: assert property ($fell(progBusy) |-> ##[0:1] standby)
    else $error("no idle after programming");
  a_busy_silent: assert property (progBusy |-> !sdaOe)
    else $error("drive while programming");
  a_standby_silent: assert property (standby |-> !sdaOe)
    else $error("drive while idle");
  a_steady_scl_high: assert property (sclIn && $past(sclIn) |->
    $stable(sdaOe)) else $error("data changed with clock high");
  a_busy_not_idle: assert property (progBusy |-> !standby)
    else $error("idle while programming");
  a_ack_holds: assert property ($rose(sdaOe) |-> sdaOe[*8])
    else $error("pull shorter than a bit slot");
endmodule // ees_two_wire_slave_properties
bind ees_two_wire_slave ees_two_wire_slave_properties #(
  .PROG_CYCLES(PROG_CYCLES)
) i_ees_two_wire_slave_properties (.ref_clk, .rst, .sclIn, .sdaIn,
  .deviceSelectBitLow, .deviceSelectBitMid, .deviceSelectBitHigh,
  .sdaOut, .sdaOe, .progBusy, .standby);

// *** sim/ees_two_wire_slave_tb_top.sv ***
`timescale 1ns/10ps
module ees_two_wire_slave_tb_top;
  localparam       PROG = 200;
  localparam [3:0] DT   = 4'h6; // Arbitrary type code
  reg        refClk;
  reg        rst;
  reg  [2:0] sel;
  reg  [7:0] hi, lo, d, r;
  reg [15:0] adjAddr;
  reg [31:0] rnd;
  reg        ack;
  wire       sclIn, sdaM, sdaOut, sdaOe, progBusy, standby;
  wire       sdaIn = sdaM & ~sdaOe; // Pull-up wire
  integer    fail_count, n_compared, cyc, seed, i, w;
  ees_two_wire_slave #(.PROG_CYCLES(PROG), .DEV_TYPE(DT)) i_ees_two_wire_slave (
    .ref_clk(refClk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
    .deviceSelectBitLow(sel[0]), .deviceSelectBitMid(sel[1]),
    .deviceSelectBitHigh(sel[2]), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .progBusy(progBusy), .standby(standby));
  ees_master_model i_ees_master_model (.refClk(refClk), .sdaIn(sdaIn),
    .scl(sclIn), .sdaDrv(sdaM));
  function [7:0] b(input x);
    b = {7'h0, x};
  endfunction
  function [7:0] sa(input rw);
    sa = {DT, sel, rw};
  endfunction
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task wrAck(input [7:0] v);
    begin
      i_ees_master_model.wr(v, ack);
      check(b(ack), 8'h1);
    end
  endtask
  task wrNak(input [7:0] v);
    begin
      i_ees_master_model.start;
      i_ees_master_model.wr(v, ack);
      check(b(ack), 8'h0);
      i_ees_master_model.stop;
    end
  endtask
  task waitIdle;
    begin
      repeat (4) @(posedge refClk);
      #1 w = 0;
      while (progBusy === 1'b1 && w < 1000) begin
        @(posedge refClk);
        #1 w = w + 1;
      end
    end
  endtask
  task finish_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    refClk = 1'b0;
    forever #10 refClk = ~refClk;
  end
  always @(posedge refClk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      finish_test;
    end
  end
  initial begin
    seed = 93;
    cyc = 0;
    fail_count = 0;
    n_compared = 0;
    sel = 3'h0;
    rst = 1'b1;
    repeat (20) @(posedge refClk);
    #1 rst = 1'b0;
    repeat (4) @(posedge refClk);
    #1 check(b(standby), 8'h1);
    check(b(progBusy), 8'h0);
    for (i = 0; i < 5; i = i + 1) begin
      rnd = $random(seed);
      sel = rnd[26:24];
      // Last byte keeps a one bit so a cut read can be recovered
      d = rnd[23:16] | ((i == 4) ? 8'h01 : 8'h00);
      {hi, lo} = (i == 0) ? 16'hffff : rnd[15:0];
      wrNak({~DT, sel, 1'b0});
      wrNak({DT, ~sel, 1'b0});
      i_ees_master_model.start;
      wrAck(sa(1'b0));
      wrAck(hi);
      wrAck(lo);
      wrAck(d);
      i_ees_master_model.stop;
      repeat (3) @(posedge refClk);
      #1 check(b(progBusy), 8'h1);
      wrNak(sa(1'b0));
      waitIdle;
      #1 check(b(standby), 8'h1);
      i_ees_master_model.start;
      i_ees_master_model.xfer(1'b1, ack);
      i_ees_master_model.start;
      wrAck(sa(1'b0));
      wrAck(hi ^ 8'hc0);
      wrAck(lo);
      i_ees_master_model.start;
      wrAck(sa(1'b1));
      i_ees_master_model.rd(1'b1, r);
      i_ees_master_model.stop;
      check(r, d);
    end
    adjAddr = {hi, lo} + 16'h1;
    i_ees_master_model.start;
    wrAck(sa(1'b0));
    wrAck(adjAddr[15:8]);
    wrAck(adjAddr[7:0]);
    wrAck(~d);
    i_ees_master_model.stop;
    waitIdle;
    i_ees_master_model.start;
    wrAck(sa(1'b0));
    wrAck(hi);
    wrAck(lo);
    i_ees_master_model.start;
    wrAck(sa(1'b1));
    i_ees_master_model.rd(1'b0, r);
    check(r, d);
    i_ees_master_model.rd(1'b1, r);
    check(r, ~d);
    i_ees_master_model.stop;
    i_ees_master_model.start;
    wrAck(sa(1'b0));
    wrAck(hi);
    wrAck(lo);
    i_ees_master_model.start;
    wrAck(sa(1'b1));
    i_ees_master_model.xfer(1'b1, ack);
    i_ees_master_model.recover;
    wrAck(sa(1'b1));
    i_ees_master_model.rd(1'b1, r);
    i_ees_master_model.stop;
    check(r, d);
    i_ees_master_model.start;
    wrAck(sa(1'b0));
    i_ees_master_model.xfer(1'b0, ack);
    rst = 1'b1;
    repeat (2) @(posedge refClk);
    #1 check(b(sdaOe), 8'h0);
    check(b(standby), 8'h1);
    check(b(sdaOut), 8'h0);
    i_ees_master_model.stop;
    rst = 1'b0;
    i_ees_master_model.start;
    wrAck(sa(1'b0));
    wrAck(hi);
    wrAck(lo);
    i_ees_master_model.start;
    wrAck(sa(1'b1));
    i_ees_master_model.rd(1'b1, r);
    i_ees_master_model.stop;
    check(r, d);
    finish_test;
  end
endmodule // ees_two_wire_slave_tb_top
